// file: rtl/ccbp_regs.svh
// Purpose: Offsets, field positions and reset values of the codec configuration register.
// Assumes: A 7-bit register index space and 16-bit register data.
// Notes:   Definitions only.
`ifndef CCBP_REGS_SVH
`define CCBP_REGS_SVH

`define CCBP_ADDR_W            7
`define CCBP_DATA_W            16
`define CCBP_CONFIG_ONE_OFFSET 7'h5C
`define CCBP_CONFIG_ONE_RESET  16'h18C0
`define CCBP_CONFIG_ONE_WMASK  16'h7FC0
`define CCBP_BANK_HI_POS       14
`define CCBP_BANK_LO_POS       13
`define CCBP_KEEP_POS          12
`define CCBP_CLKID_HI_POS      11
`define CCBP_CLKID_LO_POS      10
`define CCBP_MISC_HI_POS       9
`define CCBP_MISC_LO_POS       6
`define CCBP_BANK_IO           2'h1
`define CCBP_BANK_CODEC        2'h2
`define CCBP_CLK_BIT_12M288    2'h0
`define CCBP_CLK_XTAL_32M768   2'h1
`define CCBP_CLK_XTAL_24M576   2'h2
`define CCBP_CLK_XTAL_12M288   2'h3
`define CCBP_FEATURES          4

`endif

// file: rtl/ccbp_pkg.sv
// Purpose: Types used by the configuration register for its bank and clock decode.
// Assumes: Encodings match the constants header.
// Notes:   Types only.
package ccbp_pkg;

    typedef enum logic [1:0] {
        CCBP_BANK_NONE0 = 2'h0,
        CCBP_BANK_IO    = 2'h1,
        CCBP_BANK_CODEC = 2'h2,
        CCBP_BANK_NONE3 = 2'h3
    } ccbp_bank_t;

    typedef enum logic [1:0] {
        CCBP_CLK_BITCLK_12M288 = 2'h0,
        CCBP_CLK_XTAL_32M768   = 2'h1,
        CCBP_CLK_XTAL_24M576   = 2'h2,
        CCBP_CLK_XTAL_12M288   = 2'h3
    } ccbp_clk_src_t;

endpackage : ccbp_pkg

// file: rtl/ccbp_power_gate.sv
// Purpose: Decides, per feature, whether it stays powered.
// Assumes: Reset level is already synchronised to sys_clk.
// Notes:   All outputs registered.
`timescale 1ns/1ns
`default_nettype none
`include "ccbp_regs.svh"

module ccbp_power_gate #(
    parameter int NUM_FEATURES = `CCBP_FEATURES
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    clkEn,
    // Control
    input  wire logic                    resetHeld,
    input  wire logic                    resetPowerKeep,
    input  wire logic [NUM_FEATURES-1:0] featureEnable,
    // Results
    output logic      [NUM_FEATURES-1:0] featurePowered,
    output logic                         deviceOff
);

    logic [NUM_FEATURES-1:0] featurePowered_q;
    logic [NUM_FEATURES-1:0] featurePowered_d;
    logic                    deviceOff_q;
    logic                    deviceOff_d;

    genvar f;
    generate
        for (f = 0; f < NUM_FEATURES; f = f + 1) begin : g_feat
            // A cleared keep bit overrides every feature enable during reset.
            always_comb begin
                if (resetHeld && !resetPowerKeep) begin
                    featurePowered_d[f] = 1'b0;
                end else begin
                    featurePowered_d[f] = featureEnable[f];
                end
            end
        end
    endgenerate

    always_comb begin
        deviceOff_d = resetHeld && !resetPowerKeep;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            featurePowered_q <= '0;
            deviceOff_q      <= 1'b0;
        end else if (clkEn) begin
            featurePowered_q <= featurePowered_d;
            deviceOff_q      <= deviceOff_d;
        end
    end

    assign featurePowered = featurePowered_q;
    assign deviceOff      = deviceOff_q;

endmodule : ccbp_power_gate
`default_nettype wire

// file: rtl/ccbp_config_one.sv
// Purpose: Configuration register one of the modem codec with bank, clock and reset power control.
// Assumes: Register accesses arrive already decoded from the serial control link on sys_clk.
// Notes:   The reset pin is asynchronous and is synchronised before use.
`timescale 1ns/1ns
`default_nettype none
`include "ccbp_regs.svh"

module ccbp_config_one #(
    parameter int NUM_FEATURES = `CCBP_FEATURES
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    clkEn,
    // Register port
    input  wire logic                    regWrEn,
    input  wire logic                    regRdEn,
    input  wire logic [`CCBP_ADDR_W-1:0] regAddr,
    input  wire logic [`CCBP_DATA_W-1:0] regWrData,
    output logic      [`CCBP_DATA_W-1:0] regRdData,
    output logic                         regRdValid,
    // Device reset pin and feature enables
    input  wire logic                    resetPin_n,
    input  wire logic [NUM_FEATURES-1:0] featureEnable,
    // Bank steering
    output logic      [1:0]              bankSelect,
    output logic                         bankIoActive,
    output logic                         bankCodecActive,
    output logic                         bankReserved,
    // Core clock selection
    output logic      [1:0]              clockSourceId,
    output logic                         clockFromCrystal,
    // Power state
    output logic      [NUM_FEATURES-1:0] featurePowered,
    output logic                         deviceOff,
    output logic                         resetHeld
);

    logic [`CCBP_DATA_W-1:0] cfg_q;
    logic [`CCBP_DATA_W-1:0] cfg_d;
    logic [`CCBP_DATA_W-1:0] rdData_q;
    logic [`CCBP_DATA_W-1:0] rdData_d;
    logic                    rdValid_q;
    logic                    rdValid_d;
    logic                    resetSync1_q;
    logic                    resetSync2_q;
    logic                    resetHeld_q;
    logic                    resetHeld_d;
    logic [1:0]              bankSelect_q;
    logic [1:0]              bankSelect_d;
    logic                    bankIo_q;
    logic                    bankIo_d;
    logic                    bankCodec_q;
    logic                    bankCodec_d;
    logic                    bankRes_q;
    logic                    bankRes_d;
    logic [1:0]              clkId_q;
    logic [1:0]              clkId_d;
    logic                    clkXtal_q;
    logic                    clkXtal_d;
    logic                    addrHit;
    ccbp_pkg::ccbp_bank_t    bankField;
    ccbp_pkg::ccbp_clk_src_t clkField;

    // Register storage; only documented writable bits take the write.
    always_comb begin
        addrHit = (regAddr == `CCBP_CONFIG_ONE_OFFSET);
        cfg_d   = cfg_q;
        if (regWrEn && addrHit) begin
            // Reserved bits are dropped whatever the controller sends.
            cfg_d = regWrData & `CCBP_CONFIG_ONE_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_q <= `CCBP_CONFIG_ONE_RESET;
        end else if (clkEn) begin
            cfg_q <= cfg_d;
        end
    end

    // Read path: one cycle latency, unmapped indices read as zero.
    always_comb begin
        rdValid_d = regRdEn;
        rdData_d  = rdData_q;
        if (regRdEn) begin
            if (addrHit) begin
                rdData_d = cfg_q & `CCBP_CONFIG_ONE_WMASK;
            end else begin
                rdData_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    // Two-stage synchroniser on the asynchronous reset pin.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resetSync1_q <= 1'b1;
            resetSync2_q <= 1'b1;
        end else if (clkEn) begin
            resetSync1_q <= resetPin_n;
            resetSync2_q <= resetSync1_q;
        end
    end

    always_comb begin
        resetHeld_d = !resetSync2_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resetHeld_q <= 1'b0;
        end else if (clkEn) begin
            resetHeld_q <= resetHeld_d;
        end
    end

    // Bank steering decode.
    always_comb begin
        bankField    = ccbp_pkg::ccbp_bank_t'(cfg_q[`CCBP_BANK_HI_POS:`CCBP_BANK_LO_POS]);
        bankSelect_d = cfg_q[`CCBP_BANK_HI_POS:`CCBP_BANK_LO_POS];
        bankIo_d     = 1'b0;
        bankCodec_d  = 1'b0;
        bankRes_d    = 1'b0;
        case (bankField)
            ccbp_pkg::CCBP_BANK_IO: begin
                bankIo_d = 1'b1;
            end
            ccbp_pkg::CCBP_BANK_CODEC: begin
                bankCodec_d = 1'b1;
            end
            default: begin
                // Reserved codes steer to no bank at all.
                bankRes_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bankSelect_q <= 2'h0;
            bankIo_q     <= 1'b0;
            bankCodec_q  <= 1'b0;
            bankRes_q    <= 1'b1;
        end else if (clkEn) begin
            bankSelect_q <= bankSelect_d;
            bankIo_q     <= bankIo_d;
            bankCodec_q  <= bankCodec_d;
            bankRes_q    <= bankRes_d;
        end
    end

    // Core clock source decode; the serial interface always runs from the bit clock.
    always_comb begin
        clkField = ccbp_pkg::ccbp_clk_src_t'(cfg_q[`CCBP_CLKID_HI_POS:`CCBP_CLKID_LO_POS]);
        clkId_d  = cfg_q[`CCBP_CLKID_HI_POS:`CCBP_CLKID_LO_POS];
        case (clkField)
            ccbp_pkg::CCBP_CLK_BITCLK_12M288: begin
                clkXtal_d = 1'b0;
            end
            ccbp_pkg::CCBP_CLK_XTAL_32M768,
            ccbp_pkg::CCBP_CLK_XTAL_24M576,
            ccbp_pkg::CCBP_CLK_XTAL_12M288: begin
                clkXtal_d = 1'b1;
            end
            default: begin
                clkXtal_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clkId_q   <= `CCBP_CLK_XTAL_24M576;
            clkXtal_q <= 1'b1;
        end else if (clkEn) begin
            clkId_q   <= clkId_d;
            clkXtal_q <= clkXtal_d;
        end
    end

    // Power gating uses the synchronised reset level, so its outputs lag the pin by four cycles.
    ccbp_power_gate #(
        .NUM_FEATURES (NUM_FEATURES)
    ) u_power_gate (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .clkEn          (clkEn),
        .resetHeld      (resetHeld_q),
        .resetPowerKeep (cfg_q[`CCBP_KEEP_POS]),
        .featureEnable  (featureEnable),
        .featurePowered (featurePowered),
        .deviceOff      (deviceOff)
    );

    assign regRdData        = rdData_q;
    assign regRdValid       = rdValid_q;
    assign bankSelect       = bankSelect_q;
    assign bankIoActive     = bankIo_q;
    assign bankCodecActive  = bankCodec_q;
    assign bankReserved     = bankRes_q;
    assign clockSourceId    = clkId_q;
    assign clockFromCrystal = clkXtal_q;
    assign resetHeld        = resetHeld_q;

endmodule : ccbp_config_one
`default_nettype wire

// file: verification/ccbp_config_one_asserts.sv
// Purpose: Port checks of the configuration register.
// Assumes: clkEn stays high while checked.
// Notes:   Bound to ccbp_config_one.
`timescale 1ns/1ns
`default_nettype none
`include "ccbp_regs.svh"
module ccbp_config_one_asserts #(
    parameter int NUM_FEATURES = 4
) (
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire logic                    clkEn,
    input wire logic                    regWrEn,
    input wire logic                    regRdEn,
    input wire logic [`CCBP_ADDR_W-1:0] regAddr,
    input wire logic [`CCBP_DATA_W-1:0] regWrData,
    input wire logic [`CCBP_DATA_W-1:0] regRdData,
    input wire logic                    regRdValid,
    input wire logic                    resetPin_n,
    input wire logic [NUM_FEATURES-1:0] featureEnable,
    input wire logic [1:0]              bankSelect,
    input wire logic                    bankIoActive,
    input wire logic                    bankCodecActive,
    input wire logic                    bankReserved,
    input wire logic [1:0]              clockSourceId,
    input wire logic                    clockFromCrystal,
    input wire logic [NUM_FEATURES-1:0] featurePowered,
    input wire logic                    deviceOff,
    input wire logic                    resetHeld
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_wr;
        clkEn && regWrEn && regAddr == `CCBP_CONFIG_ONE_OFFSET;
    endsequence
    sequence s_rd;
        clkEn && regRdEn;
    endsequence
    a_bank_follow: assert property (s_wr ##1 clkEn |=> bankSelect == $past(regWrData[14:13], 2))
        else $error("bank select does not follow write");
    a_bank_decode: assert property ({bankReserved, bankCodecActive, bankIoActive} ==
        {bankSelect[0] == bankSelect[1], bankSelect == 2'h2, bankSelect == 2'h1})
        else $error("bank decode wrong");
    a_clock_decode: assert property (clockFromCrystal == (clockSourceId != 2'h0))
        else $error("clock source decode wrong");
    a_read_pulse: assert property (s_rd |=> regRdValid)
        else $error("read not answered");
    a_read_mask: assert property (s_rd |=> (regRdData & ~`CCBP_CONFIG_ONE_WMASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    a_off_blank: assert property (deviceOff |-> featurePowered == '0)
        else $error("feature powered while device off");
    a_off_held: assert property (deviceOff |-> $past(resetHeld))
        else $error("device off without reset");
    a_pin_held: assert property (!resetPin_n [*4] |-> resetHeld)
        else $error("reset pin not seen");
    a_feature_follow: assert property (!$past(rst) && !$past(resetHeld) && $past(clkEn) |->
        featurePowered == $past(featureEnable))
        else $error("features not following enables");
endmodule : ccbp_config_one_asserts
bind ccbp_config_one ccbp_config_one_asserts #(.NUM_FEATURES(NUM_FEATURES)) u_chk (.sys_clk, .rst, .clkEn,
    .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid, .resetPin_n, .featureEnable,
    .bankSelect, .bankIoActive, .bankCodecActive, .bankReserved, .clockSourceId, .clockFromCrystal,
    .featurePowered, .deviceOff, .resetHeld);
`default_nettype wire

// file: verification/ccbp_host_model.sv
// Purpose: Host side of the control link issuing register accesses.
// Assumes: One access at a time.
// Notes:   Released lines show inverted values so stale data is never mistaken.
`timescale 1ns/1ns
`default_nettype none
module ccbp_host_model (
    input  wire logic        sys_clk,
    output logic             regWrEn,
    output logic             regRdEn,
    output logic [6:0]       regAddr,
    output logic [15:0]      regWrData,
    input  wire logic [15:0] regRdData,
    input  wire logic        regRdValid
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 7'h00;
        regWrData = 16'h0000;
    end
    task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d & 16'h7FC0;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        d = 16'hDEAD;
        // The valid pulse stands for one cycle only, so look before the next edge can end it.
        for (int n = 0; n < 4; n++) begin
            #1;
            if (regRdValid === 1'b1) begin
                d = regRdData & 16'h7FC0;
                break;
            end
            @(posedge sys_clk);
        end
    endtask : read_reg
endmodule : ccbp_host_model
`default_nettype wire

// file: verification/test_codec_config_bank_power.sv
// Purpose: Register, bank, clock and reset power checks.
// Assumes: clkEn held high except in the closing freeze scenario.
// Notes:   Keep bit is rewritten while the pin is low to show the override.
`timescale 1ns/1ns
`default_nettype none
module test_codec_config_bank_power;
    logic sys_clk, rst, clkEn, regWrEn, regRdEn, regRdValid, resetPin_n;
    logic bankIoActive, bankCodecActive, bankReserved, clockFromCrystal, deviceOff, resetHeld;
    logic [6:0] regAddr;
    logic [15:0] regWrData, regRdData, rd, v;
    logic [3:0] featureEnable, featurePowered;
    logic [1:0] bankSelect, clockSourceId;
    int fail_count, samples_checked, cycles;
    ccbp_config_one u_dut (.sys_clk, .rst, .clkEn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
        .regRdValid, .resetPin_n, .featureEnable, .bankSelect, .bankIoActive, .bankCodecActive,
        .bankReserved, .clockSourceId, .clockFromCrystal, .featurePowered, .deviceOff, .resetHeld);
    ccbp_host_model u_host (.sys_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        resetPin_n = 1'b1;
        featureEnable = 4'hA;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        u_host.read_reg(7'h5C, rd);
        check("reset value", rd, 16'h18C0);
        check("clock id", 16'(clockSourceId), 16'h0002);
        for (int i = 0; i < 4; i++) begin
            v = 16'(16'h1140 | (i << 13) | (i << 10));
            u_host.write_reg(7'h5C, v);
            tick(1);
            check("bank io", 16'(bankIoActive), 16'(i == 1));
            check("bank codec", 16'(bankCodecActive), 16'(i == 2));
            check("bank reserved", 16'(bankReserved), 16'(i == 0 || i == 3));
            check("bank select", 16'(bankSelect), 16'(i));
            check("clock id", 16'(clockSourceId), 16'(i));
            check("crystal", 16'(clockFromCrystal), 16'(i != 0));
            u_host.read_reg(7'h5C, rd);
            check("readback", rd, v);
        end
        u_host.write_reg(7'h5D, 16'h0000);
        u_host.read_reg(7'h5D, rd);
        check("unmapped", rd, 16'h0000);
        u_host.read_reg(7'h5C, rd);
        check("kept", rd, 16'h7D40);
        @(posedge sys_clk);
        resetPin_n <= 1'b0;
        tick(6);
        check("held power", 16'(featurePowered), 16'h000A);
        check("held off", 16'(deviceOff), 16'h0000);
        check("reset held", 16'(resetHeld), 16'h0001);
        featureEnable <= 4'h5;
        tick(2);
        check("new enables", 16'(featurePowered), 16'h0005);
        u_host.write_reg(7'h5C, 16'h2000);
        tick(2);
        check("off", 16'(deviceOff), 16'h0001);
        check("override", 16'(featurePowered), 16'h0000);
        @(posedge sys_clk);
        resetPin_n <= 1'b1;
        tick(6);
        check("released", 16'(deviceOff), 16'h0000);
        check("run power", 16'(featurePowered), 16'h0005);
        check("reset free", 16'(resetHeld), 16'h0000);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        u_host.write_reg(7'h5C, 16'h4000);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        u_host.read_reg(7'h5C, rd);
        check("frozen write", rd, 16'h2000);
        check("frozen bank", 16'(bankIoActive), 16'h0001);
        finish_test();
    end
endmodule : test_codec_config_bank_power
`default_nettype wire
